// File: tlb_entry_mem.sv
// Entry store of the TLB: sets of four ways, registered set read.
// Assumes one clock, synchronous active-low reset and a shared clock enable.
`timescale 1ns/100ps
module tlb_entry_mem
    import tlb_test_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Controller side
    tlb_mem_if.mem m
);

    typedef struct packed {
        entry_t [SETS-1:0][WAYS-1:0] arr;
        entry_t [WAYS-1:0] rd;
    } mem_t;

    mem_t q;
    mem_t d;

    always_comb begin
        d = q;
        // Clear of all valid bits; a same-cycle entry write still lands
        if (m.clr_all) begin
            for (int s = 0; s < SETS; s++) begin
                for (int w = 0; w < WAYS; w++) begin
                    d.arr[s][w].valid = 1'b0;
                end
            end
        end
        if (m.wr_en) begin
            d.arr[m.wr_set][m.wr_way] = m.wr_entry;
        end
        if (m.rd_en) begin
            d.rd = q.arr[m.rd_set];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign m.rd_ways = q.rd;

endmodule

// File: tlb_mem_if.sv
// Carrier between the controller and the TLB entry memory.
// Assumes one clock; the controller drives requests, the memory answers.
`timescale 1ns/100ps
interface tlb_mem_if;
    import tlb_test_pkg::*;
    logic clr_all;
    logic wr_en;
    logic [SET_W-1:0] wr_set;
    logic [WAY_W-1:0] wr_way;
    entry_t wr_entry;
    logic rd_en;
    logic [SET_W-1:0] rd_set;
    entry_t [WAYS-1:0] rd_ways;

    modport ctrl (output clr_all, wr_en, wr_set, wr_way, wr_entry, rd_en, rd_set, input rd_ways);
    modport mem (input clr_all, wr_en, wr_set, wr_way, wr_entry, rd_en, rd_set, output rd_ways);
endinterface

// File: tlb_test_access_port.sv
// TLB test access controller with an AXI4-Lite register slave.
// Assumes one clock aclk, synchronous active-low reset and a clock enable.
// How it works
// - A command write with the command bit low writes one TLB entry at once while translation is off.
// - A command write with the command bit high starts an associative lookup at once while translation is off.
// - A test write tags the entry with the command linear address and fills the rest from both registers.
// - A lookup compares the tag against every way and loads the fields only on a single match.
// - The physical address field feeds a written entry and receives the matched entry's address.
// - With the hit flag set the block choice field picks the way, else the replacement pointer does.
// - After a lookup the hit flag is one on a hit and zero on a miss.
// - Each entry has a valid bit and any write to the page base register clears them all.
// - Attribute pairs 00 miss all, 01 match clear, 10 match set and 11 match either.
// - On a write a pair 01 stores zero and 10 stores one; other pairs store the true bit.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module tlb_test_access_port
    import tlb_test_pkg::*;
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // Write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // Write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // Read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);

    typedef struct packed {
        state_t st;
        logic [31:0] cmd;
        logic [31:0] data;
        logic [31:0] pbase;
        logic [31:0] mctl;
        logic [WAY_W-1:0] repl;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } regs_t;

    regs_t q;
    regs_t d;
    tlb_mem_if m ();

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pair match: 00 never, 01 when clear, 10 when set, 11 always
    function automatic logic attr_match(input logic t, input logic c, input logic x);
        return x ? t : c;
    endfunction

    tlb_entry_mem u_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .m(m.mem)
    );

    logic wr_hs;
    logic rd_hs;
    logic [ADDR_W-1:0] wr_off;
    logic [31:0] cmd_new;
    logic [WAYS-1:0] hit_vec;
    logic [2:0] hit_cnt;
    logic [WAY_W-1:0] hit_way;
    logic hit_one;
    entry_t hit_ent;

    assign wr_hs = ce && q.st == S_IDLE && awvalid && wvalid;
    assign rd_hs = ce && q.st == S_IDLE && arvalid && !(awvalid && wvalid);
    assign wr_off = awaddr & ADDR_MASK;
    assign cmd_new = merge(q.cmd, wdata, wstrb);
    assign awready = wr_hs;
    assign wready = wr_hs;
    assign arready = rd_hs;
    assign bvalid = q.st == S_BRESP;
    assign bresp = q.bresp;
    assign rvalid = q.st == S_RRESP;
    assign rdata = q.rdata;
    assign rresp = q.rresp;

    // Associative compare of the set read for a lookup
    always_comb begin
        hit_vec = '0;
        hit_cnt = '0;
        hit_way = '0;
        hit_ent = m.rd_ways[0];
        for (int w = 0; w < WAYS; w++) begin
            hit_vec[w] = m.rd_ways[w].valid == q.cmd[CMD_V]
                && m.rd_ways[w].tag == q.cmd[31:TAG_LSB]
                && attr_match(q.cmd[CMD_D], q.cmd[CMD_DN], m.rd_ways[w].dirty)
                && attr_match(q.cmd[CMD_U], q.cmd[CMD_UN], m.rd_ways[w].user)
                && attr_match(q.cmd[CMD_W], q.cmd[CMD_WN], m.rd_ways[w].writable);
            if (hit_vec[w]) begin
                hit_cnt = hit_cnt + CNT_ONE;
                hit_way = WAY_W'(w);
                hit_ent = m.rd_ways[w];
            end
        end
        hit_one = hit_cnt == CNT_ONE;
    end

    always_comb begin
        d = q;
        m.clr_all = 1'b0;
        m.wr_en = 1'b0;
        m.wr_set = q.cmd[SET_LSB +: SET_W];
        m.wr_way = q.repl;
        m.wr_entry = '0;
        m.rd_en = 1'b0;
        m.rd_set = q.cmd[SET_LSB +: SET_W];
        unique case (q.st)
            S_IDLE: begin
                if (wr_hs) begin
                    d.bresp = RESP_OKAY;
                    d.st = S_BRESP;
                    unique case (wr_off)
                        OFF_CMD: begin
                            d.cmd = cmd_new;
                            // Test hardware acts only while translation is off
                            if (!q.mctl[MCTL_PG]) begin
                                d.st = cmd_new[CMD_C] ? S_LK_RD : S_TLB_WR;
                            end
                        end
                        OFF_DATA: d.data = merge(q.data, wdata, wstrb);
                        OFF_PBASE: begin
                            d.pbase = merge(q.pbase, wdata, wstrb);
                            m.clr_all = 1'b1;
                        end
                        OFF_MCTL: d.mctl = merge(q.mctl, wdata, wstrb);
                        default: d.bresp = RESP_DECERR;
                    endcase
                end else if (rd_hs) begin
                    d.rresp = RESP_OKAY;
                    d.st = S_RRESP;
                    unique case (araddr & ADDR_MASK)
                        OFF_CMD: d.rdata = q.cmd;
                        OFF_DATA: d.rdata = q.data;
                        OFF_PBASE: d.rdata = q.pbase;
                        OFF_MCTL: d.rdata = q.mctl;
                        default: begin
                            d.rdata = '0;
                            d.rresp = RESP_DECERR;
                        end
                    endcase
                end
            end
            S_TLB_WR: begin
                m.wr_en = 1'b1;
                m.wr_way = q.data[DAT_PL] ? q.data[DAT_REP_LSB +: WAY_W] : q.repl;
                m.wr_entry.valid = q.cmd[CMD_V];
                m.wr_entry.tag = q.cmd[31:TAG_LSB];
                m.wr_entry.phys = q.data[31:PHYS_LSB];
                m.wr_entry.dirty = q.cmd[CMD_D];
                m.wr_entry.user = q.cmd[CMD_U];
                m.wr_entry.writable = q.cmd[CMD_W];
                if (!q.data[DAT_PL]) begin
                    d.repl = q.repl + WAY_ONE;
                end
                d.st = S_BRESP;
            end
            S_LK_RD: begin
                m.rd_en = 1'b1;
                d.st = S_LK_CMP;
            end
            S_LK_CMP: begin
                d.data[DAT_PL] = hit_one;
                if (hit_one) begin
                    d.data[31:PHYS_LSB] = hit_ent.phys;
                    d.data[DAT_REP_LSB +: WAY_W] = hit_way;
                    d.cmd[CMD_V] = hit_ent.valid;
                    d.cmd[CMD_D] = hit_ent.dirty;
                    d.cmd[CMD_DN] = !hit_ent.dirty;
                    d.cmd[CMD_U] = hit_ent.user;
                    d.cmd[CMD_UN] = !hit_ent.user;
                    d.cmd[CMD_W] = hit_ent.writable;
                    d.cmd[CMD_WN] = !hit_ent.writable;
                end
                d.st = S_BRESP;
            end
            S_BRESP: begin
                if (bready) begin
                    d.st = S_IDLE;
                end
            end
            S_RRESP: begin
                if (rready) begin
                    d.st = S_IDLE;
                end
            end
            default: d.st = S_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q.st <= S_IDLE;
            q.cmd <= CMD_RST;
            q.data <= DATA_RST;
            q.pbase <= PBASE_RST;
            q.mctl <= MCTL_RST;
            q.repl <= '0;
            q.bresp <= RESP_OKAY;
            q.rdata <= '0;
            q.rresp <= RESP_OKAY;
        end else if (ce) begin
            q <= d;
        end
    end

    paging_block_a: assert property (ce && wr_hs && wr_off == OFF_CMD && q.mctl[MCTL_PG] |=> q.st == S_BRESP)
        else $error("command acted while translation on");

    write_start_a: assert property (ce && wr_hs && wr_off == OFF_CMD
        && !q.mctl[MCTL_PG] && !cmd_new[CMD_C] |=> q.st == S_TLB_WR ##0 m.wr_en)
        else $error("entry write did not start");

    lookup_start_a: assert property (ce && wr_hs && wr_off == OFF_CMD
        && !q.mctl[MCTL_PG] && cmd_new[CMD_C] |=> m.rd_en && m.rd_set == $past(cmd_new[SET_LSB +: SET_W]))
        else $error("lookup did not start");

    entry_tag_a: assert property (m.wr_en |-> m.wr_entry.tag == q.cmd[31:TAG_LSB]
        && m.wr_entry.phys == q.data[31:PHYS_LSB])
        else $error("written entry fields wrong");

    lookup_load_a: assert property (ce && q.st == S_LK_CMP && hit_one
        |=> q.data[31:PHYS_LSB] == $past(hit_ent.phys) && q.data[DAT_REP_LSB +: WAY_W] == $past(hit_way))
        else $error("matched entry not loaded");

    way_select_a: assert property (m.wr_en
        |-> m.wr_way == (q.data[DAT_PL] ? q.data[DAT_REP_LSB +: WAY_W] : q.repl))
        else $error("wrong way written");

    repl_step_a: assert property (ce && m.wr_en && !q.data[DAT_PL] |=> q.repl == $past(q.repl) + WAY_ONE)
        else $error("replacement pointer did not advance");

    hit_flag_a: assert property (ce && q.st == S_LK_CMP |=> q.data[DAT_PL] == $past(hit_one) ##1 1'b1)
        else $error("hit flag wrong after lookup");

    valid_clear_a: assert property (wr_hs && wr_off == OFF_PBASE |-> m.clr_all)
        else $error("page base write did not clear valids");

    pair_miss_a: assert property (ce && q.st == S_LK_CMP && !q.cmd[CMD_D] && !q.cmd[CMD_DN]
        |=> !q.data[DAT_PL])
        else $error("pair 00 did not miss");

    attr_store_a: assert property (m.wr_en && q.cmd[CMD_U] != q.cmd[CMD_UN]
        |-> m.wr_entry.user == q.cmd[CMD_U])
        else $error("attribute stored wrong");

    multi_miss_a: assert property (ce && q.st == S_LK_CMP && hit_cnt > CNT_ONE
        |=> !q.data[DAT_PL] && $stable(q.data[31:PHYS_LSB]))
        else $error("multiple match not a miss");

    write_state_a: assert property (ce && q.st == S_TLB_WR
        |=> q.st == S_BRESP && !m.wr_en)
        else $error("entry write not single");

    write_gate_a: assert property (q.st != S_TLB_WR |-> !m.wr_en)
        else $error("entry write outside write state");

    lookup_step_a: assert property (ce && q.st == S_LK_RD |=> q.st == S_LK_CMP)
        else $error("lookup did not reach compare");

    read_gate_a: assert property (q.st != S_LK_RD |-> !m.rd_en)
        else $error("set read outside lookup");

    xlat_idle_a: assert property (ce && wr_hs && q.mctl[MCTL_PG]
        |=> !m.wr_en && !m.rd_en)
        else $error("entry access while translation on");

    entry_valid_a: assert property (m.wr_en |-> m.wr_entry.valid == q.cmd[CMD_V])
        else $error("written valid bit wrong");

    single_hit_a: assert property (hit_one |-> $onehot(hit_vec))
        else $error("hit reported without single match");

    cmd_dirty_a: assert property (ce && q.st == S_LK_CMP && hit_one
        |=> q.cmd[CMD_D] == $past(hit_ent.dirty) && q.cmd[CMD_DN] != q.cmd[CMD_D]
        && q.cmd[CMD_V] == $past(hit_ent.valid))
        else $error("matched dirty or valid not loaded");

    cmd_user_a: assert property (ce && q.st == S_LK_CMP && hit_one
        |=> q.cmd[CMD_U] == $past(hit_ent.user) && q.cmd[CMD_UN] != q.cmd[CMD_U]
        && q.cmd[CMD_W] == $past(hit_ent.writable) && q.cmd[CMD_WN] != q.cmd[CMD_W])
        else $error("matched user or writable not loaded");

    miss_flag_a: assert property (ce && q.st == S_LK_CMP && hit_vec == '0 |=> !q.data[DAT_PL])
        else $error("hit flag set without match");

    miss_keep_a: assert property (ce && q.st == S_LK_CMP && !hit_one
        |=> $stable(q.data[31:PHYS_LSB]) && $stable(q.data[DAT_REP_LSB +: WAY_W]))
        else $error("fields changed on a miss");

    repl_hold_a: assert property (ce && m.wr_en && q.data[DAT_PL] |=> $stable(q.repl))
        else $error("replacement pointer moved on selected write");

    user_miss_a: assert property (ce && q.st == S_LK_CMP && !q.cmd[CMD_U] && !q.cmd[CMD_UN]
        |=> !q.data[DAT_PL])
        else $error("user pair 00 did not miss");

    write_miss_a: assert property (ce && q.st == S_LK_CMP && !q.cmd[CMD_W] && !q.cmd[CMD_WN]
        |=> !q.data[DAT_PL])
        else $error("writable pair 00 did not miss");

    dirty_store_a: assert property (m.wr_en && q.cmd[CMD_D] != q.cmd[CMD_DN]
        |-> m.wr_entry.dirty == q.cmd[CMD_D])
        else $error("dirty bit stored wrong");

    writable_store_a: assert property (m.wr_en && q.cmd[CMD_W] != q.cmd[CMD_WN]
        |-> m.wr_entry.writable == q.cmd[CMD_W])
        else $error("writable bit stored wrong");

endmodule

// File: tlb_test_access_port_test.sv
// Self-checking testbench for the TLB test access block.
// Assumes the register map and field layout of tlb_test_pkg and an AXI4-Lite master.
`timescale 1ns/100ps
module tlb_test_access_port_test
    import tlb_test_pkg::*;
;
    logic aclk, aresetn, ce;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, dr, cr;
    logic [1:0] bresp, rresp;
    int err_count, check_count, cyc;
    localparam logic [19:0] LA = 20'h5a00b;
    localparam logic [19:0] LB = 20'h00005;
    localparam logic [19:0] LC = 20'h00015;
    localparam logic [19:0] LD = 20'h00027;

    tlb_test_access_port uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    function automatic logic [31:0] mk(input logic [19:0] l, input logic v, input logic [1:0] d, u, w,
                                       input logic c);
        return {l, v, d, u, w, 4'h0, c};
    endfunction

    function automatic logic [31:0] dt(input logic [19:0] p, input logic pl, input logic [1:0] r);
        return {p, 7'h0, pl, r, 2'h0};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge aclk);
        while (awready !== 1'b1 || wready !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge aclk);
        while (bvalid !== 1'b1) @(negedge aclk);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge aclk);
        while (arready !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        arvalid <= 1'b0;
        @(negedge aclk);
        while (rvalid !== 1'b1) @(negedge aclk);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        d = rdata;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // Clears the data register, runs one lookup and reads both registers back
    task automatic lookup(input logic [31:0] c);
        wr(OFF_DATA, 32'h0, RESP_OKAY);
        wr(OFF_CMD, c, RESP_OKAY);
        rd(OFF_DATA, RESP_OKAY, dr);
        rd(OFF_CMD, RESP_OKAY, cr);
    endtask

    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            rd(5'(i * 4), RESP_OKAY, dr);
            chk("reset value", 32'h0, dr);
        end
        wr(5'h10, 32'hffff_ffff, RESP_DECERR);
        rd(5'h10, RESP_DECERR, dr);
        chk("unmapped data", 32'h0, dr);
        $display("t_reset done");
    endtask

    task automatic t_write_lookup;
        wr(OFF_DATA, dt(20'hab123, 1'b1, 2'h2), RESP_OKAY);
        wr(OFF_CMD, mk(LA, 1'b1, 2'b10, 2'b01, 2'b10, 1'b0), RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            lookup(mk(LA, 1'b1, 2'(i), 2'b11, 2'b11, 1'b1));
            chk("hit flag", {31'h0, i >= 2}, {31'h0, dr[DAT_PL]});
            if (i >= 2) begin
                chk("data after hit", dt(20'hab123, 1'b1, 2'h2), dr);
                chk("command after hit", mk(LA, 1'b1, 2'b10, 2'b01, 2'b10, 1'b1), cr);
            end
        end
        lookup(mk(LA, 1'b1, 2'b11, 2'b10, 2'b11, 1'b1));
        chk("user mismatch flag", 32'h0, {31'h0, dr[DAT_PL]});
        $display("t_write_lookup done");
    endtask

    task automatic t_clear;
        wr(OFF_PBASE, 32'h0000_1000, RESP_OKAY);
        lookup(mk(LA, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1));
        chk("flag after clear", 32'h0, {31'h0, dr[DAT_PL]});
        $display("t_clear done");
    endtask

    task automatic t_repl;
        wr(OFF_DATA, dt(20'h11111, 1'b0, 2'h3), RESP_OKAY);
        wr(OFF_CMD, mk(LB, 1'b1, 2'b10, 2'b10, 2'b10, 1'b0), RESP_OKAY);
        wr(OFF_DATA, dt(20'h22222, 1'b0, 2'h3), RESP_OKAY);
        wr(OFF_CMD, mk(LC, 1'b1, 2'b10, 2'b10, 2'b10, 1'b0), RESP_OKAY);
        lookup(mk(LB, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1));
        chk("first pointer way", dt(20'h11111, 1'b1, 2'h0), dr);
        lookup(mk(LC, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1));
        chk("second pointer way", dt(20'h22222, 1'b1, 2'h1), dr);
        $display("t_repl done");
    endtask

    task automatic t_xlat;
        wr(OFF_MCTL, 32'h8000_0000, RESP_OKAY);
        rd(OFF_MCTL, RESP_OKAY, dr);
        chk("machine control", 32'h8000_0000, dr);
        wr(OFF_DATA, dt(20'h44444, 1'b1, 2'h3), RESP_OKAY);
        wr(OFF_CMD, mk(LD, 1'b1, 2'b10, 2'b10, 2'b10, 1'b0), RESP_OKAY);
        wr(OFF_MCTL, 32'h0, RESP_OKAY);
        lookup(mk(LD, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1));
        chk("flag with translation on", 32'h0, {31'h0, dr[DAT_PL]});
        $display("t_xlat done");
    endtask

    task automatic t_multi;
        wr(OFF_DATA, dt(20'h33333, 1'b1, 2'h3), RESP_OKAY);
        wr(OFF_CMD, mk(LB, 1'b1, 2'b10, 2'b10, 2'b10, 1'b0), RESP_OKAY);
        lookup(mk(LB, 1'b1, 2'b11, 2'b11, 2'b11, 1'b1));
        chk("double match flag", 32'h0, {31'h0, dr[DAT_PL]});
        $display("t_multi done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hung handshake short
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        err_count = 0;
        check_count = 0;
        cyc = 0;
        aresetn = 1'b0;
        ce = 1'b1;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 5'h00;
        araddr = 5'h00;
        wdata = 32'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_write_lookup();
        t_clear();
        t_repl();
        t_xlat();
        t_multi();
        final_report();
    end
endmodule

// File: tlb_test_pkg.sv
// Constants, register layout and types for the TLB test access block.
// Shared by the controller, the entry memory and their carrier interface.
package tlb_test_pkg;

    // Register map on the AXI4-Lite slave, byte addresses
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_CMD = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_DATA = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_PBASE = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_MCTL = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h1c;

    localparam logic [31:0] CMD_RST = 32'h0000_0000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [31:0] PBASE_RST = 32'h0000_0000;
    localparam logic [31:0] MCTL_RST = 32'h0000_0000;

    // Command register fields
    localparam int CMD_C = 0;
    localparam int CMD_WN = 5;
    localparam int CMD_W = 6;
    localparam int CMD_UN = 7;
    localparam int CMD_U = 8;
    localparam int CMD_DN = 9;
    localparam int CMD_D = 10;
    localparam int CMD_V = 11;
    localparam int LIN_LSB = 12;
    localparam int SET_LSB = 12;
    localparam int TAG_LSB = 15;

    // Data register fields
    localparam int DAT_REP_LSB = 2;
    localparam int DAT_PL = 4;
    localparam int PHYS_LSB = 12;

    // Machine control register field
    localparam int MCTL_PG = 31;

    // TLB geometry: four associative blocks of eight sets
    localparam int WAYS = 4;
    localparam int SETS = 8;
    localparam int WAY_W = 2;
    localparam int SET_W = 3;
    localparam int TAG_W = 17;
    localparam int PHYS_W = 20;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [WAY_W-1:0] WAY_ONE = 2'h1;
    localparam logic [2:0] CNT_ONE = 3'h1;

    typedef struct packed {
        logic valid;
        logic [TAG_W-1:0] tag;
        logic [PHYS_W-1:0] phys;
        logic dirty;
        logic user;
        logic writable;
    } entry_t;

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_TLB_WR = 6'b000010,
        S_LK_RD = 6'b000100,
        S_LK_CMP = 6'b001000,
        S_BRESP = 6'b010000,
        S_RRESP = 6'b100000
    } state_t;

endpackage
